// ### nric_pkg.sv
// constants, types and register map of the nand command host
package nric_pkg;
	localparam int          CLK_MHZ         = 100;
	localparam int          T_STROBE_NS     = 40;
	localparam int          STROBE_CYC      = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
	localparam int          T_WB_NS         = 100;
	localparam int          WB_CYC          = (T_WB_NS * CLK_MHZ + 999) / 1000;
	localparam int          T_RST_MAX_US    = 1000;
	localparam int          RST_MAX_CYC     = T_RST_MAX_US * CLK_MHZ;
	localparam logic [7:0]  A_CTRL          = 8'h00;
	localparam logic [7:0]  A_CYCLE         = 8'h04;
	localparam logic [7:0]  A_STATUS        = 8'h08;
	localparam logic [7:0]  A_ERRCLR        = 8'h0C;
	localparam logic [7:0]  A_CRC           = 8'h10;
	localparam int          CTRL_WP         = 0;
	localparam int          CTRL_OTP        = 1;
	localparam int          CYC_KIND_LSB    = 8;
	localparam int          CYC_WAIT        = 10;
	localparam logic [1:0]  K_CMD           = 2'h0;
	localparam logic [1:0]  K_ADDR          = 2'h1;
	localparam logic [1:0]  K_DIN           = 2'h2;
	localparam logic [1:0]  K_DOUT          = 2'h3;
	localparam logic [7:0]  C_READ          = 8'h00;
	localparam logic [7:0]  C_PROG          = 8'h80;
	localparam logic [7:0]  C_CONF_PROG     = 8'h10;
	localparam logic [7:0]  C_CONF_CACHEP   = 8'h15;
	localparam logic [7:0]  C_CONF_READ     = 8'h30;
	localparam logic [7:0]  C_CACHE_SEQ     = 8'h31;
	localparam logic [7:0]  C_CACHE_LAST    = 8'h3F;
	localparam logic [7:0]  C_STATUS        = 8'h70;
	localparam logic [7:0]  C_STATUS_ENH    = 8'h78;
	localparam logic [7:0]  C_READ_ID       = 8'h90;
	localparam logic [7:0]  C_PARAM         = 8'hEC;
	localparam logic [7:0]  C_SET_FEAT      = 8'hEF;
	localparam logic [7:0]  C_RESET         = 8'hFF;
	localparam logic [2:0]  OTP_ADDR_CYC    = 3'h5;
	localparam logic [7:0]  ST_RST_WP_HI    = 8'hE0;
	localparam logic [7:0]  ST_RST_WP_LO    = 8'h60;
	localparam int          ST_ARRAY_READY_FLAG_BIT = 5;
	localparam logic [15:0] CRC_INIT        = 16'h4F4E;
	localparam logic [15:0] CRC_POLY        = 16'h8005;
	localparam logic [7:0]  P_CRC_LO        = 8'hFE;
	localparam logic [7:0]  P_CRC_HI        = 8'hFF;
	typedef enum logic [2:0] {S_IDLE, S_LOW, S_HIGH, S_WB, S_RB} nric_st_t;
	typedef struct packed {
		nric_st_t    st;
		logic [1:0]  kind;
		logic        wait_rb;
		logic [16:0] cnt;
		logic        ce_n, cle, ale, we_n, re_n, dq_oe_n;
		logic [7:0]  dq_o;
		logic [7:0]  dq_s1, dq_s2;
		logic        rb_s1, rb_s2;
		logic        wp_n, otp_seq;
		logic        init_done, otp_en, id_mode, param_mode, array_ready_flag;
		logic        setf, stat_rd, rst_chk;
		logic [7:0]  first, prev_op;
		logic [2:0]  acnt;
		logic        din;
		logic [7:0]  rdata, pcnt;
		logic [15:0] crc;
		logic        crc_lo_ok, crc_ok, crc_valid;
		logic        err_rej, err_tmo, err_stat;
		logic [31:0] prdata;
	} nric_state_t;
endpackage : nric_pkg

// ### nric_host.sv
// host controller issuing reset, id, parameter page and otp cycles to a nand target
//
// Contract
// - otp lock is 80h, five addresses, no data, then 10h; never while busy.
// - otp program is 80h, five addresses, data, then 10h; never while busy.
// - otp read is 00h, five addresses, 30h, no data; never while busy.
// - otp sequences only after set features with the otp feature address.
// - cache read while array busy only after page read or cache read.
// - cache program while array busy only after another cache program.
// - internal data move source and destination stay within one plane; the host does not check planes.
// - reset is the first command after power-on; busy lasts at most 1 ms.
// - read id is issued only when every logical unit is idle.
// - parameter page command only when idle; mode held until next command.
// - after status polling issue 00h; no enhanced status while busy or output; the host refuses 78h during parameter page output only, not read id output.
// - three 256-byte parameter copies with crc; check and fall back.
`timescale 1ns/1ps
`default_nettype none
module nric_host
	import nric_pkg::*;
#(
	parameter int         BUSY_MAX_CYC = RST_MAX_CYC,
	parameter logic [7:0] OTP_FEAT     = 8'h90
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             nand_ce_n,
	output logic             nand_cle,
	output logic             nand_ale,
	output logic             nand_we_n,
	output logic             nand_re_n,
	output logic             nand_wp_n,
	output logic      [7:0]  nand_dq_o,
	output logic             nand_dq_oe_n,
	input  wire logic [7:0]  nand_dq_i,
	input  wire logic        nand_rb_n
);
	localparam logic [16:0] STB_LAST = 17'(STROBE_CYC - 1);
	localparam logic [16:0] WB_LAST  = 17'(WB_CYC - 1);
	localparam logic [16:0] TMO      = 17'(BUSY_MAX_CYC);

	nric_state_t q, d;

	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			if (r[15] ^ b[i])
				r = {r[14:0], 1'b0} ^ CRC_POLY;
			else
				r = {r[14:0], 1'b0};
		end
		return r;
	endfunction : crc_step

	logic       wr_acc, rd_setup, mapped;
	logic       cyc_wr, rdy, bad;
	logic [7:0] b;
	logic [1:0] k;

	assign mapped   = paddr == A_CTRL || paddr == A_CYCLE || paddr == A_STATUS ||
	                  paddr == A_ERRCLR || paddr == A_CRC;
	assign wr_acc   = psel && penable && pwrite && mapped;
	assign rd_setup = psel && !penable && !pwrite;
	assign cyc_wr   = wr_acc && paddr == A_CYCLE;
	assign rdy      = q.rb_s2;
	assign b        = pwdata[7:0];
	assign k        = pwdata[CYC_KIND_LSB +: 2];

	// a refused cycle never reaches the pins; software sees err_rej
	always_comb begin
		bad = q.st != S_IDLE;
		if (!q.init_done && !(k == K_CMD && b == C_RESET))
			bad = 1'b1;
		if (k == K_CMD) begin
			if (!rdy && b != C_RESET && b != C_STATUS)
				bad = 1'b1;
			if (b == C_STATUS_ENH && (!rdy || q.param_mode))
				bad = 1'b1;
			if ((b == C_CACHE_SEQ || b == C_CACHE_LAST) && !q.array_ready_flag &&
			    !(q.prev_op == C_CONF_READ || q.prev_op == C_CACHE_SEQ ||
			      q.prev_op == C_CACHE_LAST))
				bad = 1'b1;
			if (b == C_CONF_CACHEP && !q.array_ready_flag && q.prev_op != C_CONF_CACHEP)
				bad = 1'b1;
			if ((b == C_PROG || b == C_READ) && q.otp_seq && !q.otp_en)
				bad = 1'b1;
			if (q.otp_seq && b == C_CONF_PROG &&
			    (q.first != C_PROG || q.acnt != OTP_ADDR_CYC))
				bad = 1'b1;
			if (q.otp_seq && b == C_CONF_READ &&
			    (q.first != C_READ || q.acnt != OTP_ADDR_CYC || q.din))
				bad = 1'b1;
		end
	end

	always_comb begin
		d = q;
		d.dq_s1 = nand_dq_i;
		d.dq_s2 = q.dq_s1;
		d.rb_s1 = nand_rb_n;
		d.rb_s2 = q.rb_s1;
		if (wr_acc && paddr == A_CTRL) begin
			d.wp_n    = pwdata[CTRL_WP];
			d.otp_seq = pwdata[CTRL_OTP];
		end
		if (wr_acc && paddr == A_ERRCLR) begin
			d.err_rej  = q.err_rej & ~pwdata[0];
			d.err_tmo  = q.err_tmo & ~pwdata[1];
			d.err_stat = q.err_stat & ~pwdata[2];
		end
		if (cyc_wr && bad)
			d.err_rej = 1'b1;
		case (q.st)
			S_IDLE: begin
				if (cyc_wr && !bad) begin
					d.st      = S_LOW;
					d.cnt     = STB_LAST;
					d.kind    = k;
					d.wait_rb = pwdata[CYC_WAIT];
					d.ce_n    = 1'b0;
					d.cle     = k == K_CMD;
					d.ale     = k == K_ADDR;
					d.we_n    = k == K_DOUT;
					d.re_n    = k != K_DOUT;
					d.dq_oe_n = k == K_DOUT;
					d.dq_o    = b;
					case (k)
						K_CMD: begin
							d.setf    = b == C_SET_FEAT;
							d.stat_rd = b == C_STATUS;
							if (b != C_STATUS && b != C_READ) begin
								d.id_mode    = b == C_READ_ID;
								d.param_mode = b == C_PARAM;
							end
							if (b != C_STATUS && b != C_READ && b != C_PROG)
								d.prev_op = b;
							if (b == C_READ || b == C_PROG || b == C_PARAM ||
							    b == C_READ_ID || b == C_SET_FEAT) begin
								d.first = b;
								d.acnt  = 3'h0;
								d.din   = 1'b0;
							end
							if (b == C_RESET) begin
								// aborts whatever the target was doing
								d.wait_rb    = 1'b1;
								d.init_done  = 1'b1;
								d.id_mode    = 1'b0;
								d.param_mode = 1'b0;
								d.otp_en     = 1'b0;
								d.prev_op    = 8'h00;
								d.first      = 8'h00;
								d.acnt       = 3'h0;
								d.din        = 1'b0;
								d.array_ready_flag = 1'b1;
								d.crc_valid  = 1'b0;
								d.rst_chk    = 1'b1;
							end
						end
						K_ADDR: begin
							if (q.acnt != 3'h7)
								d.acnt = q.acnt + 3'h1;
							if (q.setf && b == OTP_FEAT)
								d.otp_en = 1'b1;
							if (q.first == C_PARAM) begin
								d.wait_rb   = 1'b1;
								d.crc       = CRC_INIT;
								d.pcnt      = 8'h00;
								d.crc_valid = 1'b0;
							end
						end
						K_DIN: d.din = 1'b1;
						default: ;
					endcase
				end
			end
			S_LOW: begin
				if (q.cnt == 17'h0) begin
					d.st   = S_HIGH;
					d.cnt  = STB_LAST;
					d.we_n = 1'b1;
					d.re_n = 1'b1;
				end else
					d.cnt = q.cnt - 17'h1;
			end
			S_HIGH: begin
				// the synchroniser lags two edges, so this still sees the low phase
				if (q.cnt == STB_LAST && q.kind == K_DOUT) begin
					d.rdata = q.dq_s2;
					if (q.stat_rd) begin
						d.array_ready_flag = q.dq_s2[ST_ARRAY_READY_FLAG_BIT];
						if (q.rst_chk) begin
							d.rst_chk = 1'b0;
							if (q.dq_s2 != (q.wp_n ? ST_RST_WP_HI : ST_RST_WP_LO))
								d.err_stat = 1'b1;
						end
					end else if (q.param_mode) begin
						// each 256-byte copy checked in turn; wrap starts the next
						d.pcnt = q.pcnt + 8'h1;
						if (q.pcnt == P_CRC_LO)
							d.crc_lo_ok = q.dq_s2 == q.crc[7:0];
						else if (q.pcnt == P_CRC_HI) begin
							d.crc_ok    = q.crc_lo_ok && q.dq_s2 == q.crc[15:8];
							d.crc_valid = 1'b1;
							d.crc       = CRC_INIT;
						end else
							d.crc = crc_step(q.crc, q.dq_s2);
					end
				end
				if (q.cnt == 17'h0) begin
					d.cle     = 1'b0;
					d.ale     = 1'b0;
					d.dq_oe_n = 1'b1;
					d.cnt     = WB_LAST;
					d.st      = q.wait_rb ? S_WB : S_IDLE;
					d.ce_n    = !q.wait_rb;
				end else
					d.cnt = q.cnt - 17'h1;
			end
			S_WB: begin
				if (q.cnt == 17'h0) begin
					d.st  = S_RB;
					d.cnt = 17'h0;
				end else
					d.cnt = q.cnt - 17'h1;
			end
			S_RB: begin
				if (rdy) begin
					d.st   = S_IDLE;
					d.ce_n = 1'b1;
				end else if (q.cnt >= TMO) begin
					d.st      = S_IDLE;
					d.ce_n    = 1'b1;
					d.err_tmo = 1'b1;
				end else
					d.cnt = q.cnt + 17'h1;
			end
			default: d.st = S_IDLE;
		endcase
		if (rd_setup) begin
			case (paddr)
				A_CTRL:   d.prdata = {30'h0, q.otp_seq, q.wp_n};
				A_STATUS: d.prdata = {8'h0, q.rdata, 5'h0, q.err_stat, q.err_tmo,
				                      q.err_rej, q.crc_valid, q.crc_ok, q.otp_en,
				                      q.param_mode, q.id_mode, q.init_done, rdy,
				                      q.st != S_IDLE};
				A_CRC:    d.prdata = {16'h0, q.crc};
				default:  d.prdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q            <= '0;
			q.st         <= S_IDLE;
			q.ce_n       <= 1'b1;
			q.we_n       <= 1'b1;
			q.re_n       <= 1'b1;
			q.dq_oe_n    <= 1'b1;
			q.array_ready_flag <= 1'b1;
			q.crc        <= CRC_INIT;
		end else
			q <= d;
	end

	assign prdata       = q.prdata;
	assign pready       = 1'b1;
	assign pslverr      = psel && penable && !mapped;
	assign nand_ce_n    = q.ce_n;
	assign nand_cle     = q.cle;
	assign nand_ale     = q.ale;
	assign nand_we_n    = q.we_n;
	assign nand_re_n    = q.re_n;
	assign nand_wp_n    = q.wp_n;
	assign nand_dq_o    = q.dq_o;
	assign nand_dq_oe_n = q.dq_oe_n;
endmodule : nric_host
`default_nettype wire

// ### nric_host_assertions.sv
// pin and bus assertions for the nand command host
`timescale 1ns/1ps
`default_nettype none
module nric_host_assertions
	import nric_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        nand_ce_n,
	input wire logic        nand_cle,
	input wire logic        nand_ale,
	input wire logic        nand_we_n,
	input wire logic        nand_re_n,
	input wire logic        nand_wp_n,
	input wire logic [7:0]  nand_dq_o,
	input wire logic        nand_dq_oe_n,
	input wire logic [7:0]  nand_dq_i,
	input wire logic        nand_rb_n
);
	logic ff_seen_q;
	logic map_ok;
	assign map_ok = paddr inside {A_CTRL, A_CYCLE, A_STATUS, A_ERRCLR, A_CRC};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) ff_seen_q <= 1'b0;
		else if (!nand_we_n && nand_cle && nand_dq_o == C_RESET) ff_seen_q <= 1'b1;
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_we_low; !nand_we_n [*4]; endsequence
	sequence s_rst_sent; $rose(nand_we_n) && nand_cle && nand_dq_o == C_RESET; endsequence
	property p_ready; psel && penable |-> pready; endproperty
	property p_slverr; psel && penable |-> pslverr == !map_ok; endproperty
	property p_strobe; $fell(nand_we_n) |-> s_we_low ##1 nand_we_n; endproperty
	property p_sel; !nand_we_n || !nand_re_n |-> !nand_ce_n; endproperty
	property p_drive; !nand_we_n |-> !nand_dq_oe_n && (nand_cle != nand_ale || !nand_cle); endproperty
	property p_release; !nand_re_n |-> nand_dq_oe_n && nand_we_n; endproperty
	property p_first; !nand_we_n && nand_cle |-> ff_seen_q || nand_dq_o == C_RESET; endproperty
	property p_rst_busy; s_rst_sent |-> !nand_ce_n [*4]; endproperty
	property p_idle; nand_ce_n |-> nand_we_n && nand_re_n && nand_dq_oe_n; endproperty
	property p_wp;
		psel && penable && pwrite && paddr == A_CTRL |=> nand_wp_n == $past(pwdata[CTRL_WP]);
	endproperty
	a_ready: assert property (p_ready) else $error("pready low in access");
	a_slverr: assert property (p_slverr) else $error("pslverr wrong for address");
	a_strobe: assert property (p_strobe) else $error("write strobe width wrong");
	a_sel: assert property (p_sel) else $error("strobe without chip enable");
	a_drive: assert property (p_drive) else $error("write strobe without driven bus");
	a_release: assert property (p_release) else $error("bus driven during read");
	a_first: assert property (p_first) else $error("command before reset");
	a_rst_busy: assert property (p_rst_busy) else $error("reset wait dropped early");
	a_idle: assert property (p_idle) else $error("strobe while deselected");
	a_wp: assert property (p_wp) else $error("write protect not updated");
endmodule : nric_host_assertions
bind nric_host nric_host_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .nand_ce_n(nand_ce_n), .nand_cle(nand_cle),
	.nand_ale(nand_ale), .nand_we_n(nand_we_n), .nand_re_n(nand_re_n), .nand_wp_n(nand_wp_n),
	.nand_dq_o(nand_dq_o), .nand_dq_oe_n(nand_dq_oe_n), .nand_dq_i(nand_dq_i),
	.nand_rb_n(nand_rb_n));
`default_nettype wire

// ### nric_tgt.sv
// behavioural nand target for reset, status, id and parameter reads
`timescale 1ns/1ps
`default_nettype none
module nric_tgt
	import nric_pkg::*;
#(
	parameter logic [7:0] MFR = 8'h5A, // arbitrary
	parameter logic [7:0] DEV = 8'hA5  // arbitrary
) (
	input  wire logic       pclk,
	input  wire logic       ce_n,
	input  wire logic       cle,
	input  wire logic       ale,
	input  wire logic       we_n,
	input  wire logic       re_n,
	input  wire logic       wp_n,
	input  wire logic [7:0] dq_i,
	output logic      [7:0] dq_o,
	output logic            rb_n
);
	logic [7:0] md = 8'h00, adr = 8'h00, cur = 8'h00;
	logic [7:0] sig [4] = '{8'h4F, 8'h4E, 8'h46, 8'h49};
	logic       we_q = 1'b1, re_q = 1'b1, st = 1'b0, ab = 1'b0, pa = 1'b0;
	int         idx = 0, bcnt = 0;
	// crc of one parameter copy, bytes 0..253, msb first
	function automatic logic [15:0] pcrc();
		logic [15:0] c;
		logic [7:0]  v;
		logic        fb;
		c = CRC_INIT;
		for (int j = 0; j < 254; j++) begin
			v = j < 4 ? sig[j] : 8'h00;
			for (int n = 7; n >= 0; n--) begin
				fb = c[15] ^ v[n];
				c = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
			end
		end
		return c;
	endfunction : pcrc
	function automatic logic [7:0] byt(input int i);
		logic [7:0]  t [5];
		logic [15:0] c;
		int          j;
		t = '{MFR, DEV, 8'h80, 8'h26, 8'h62};
		c = pcrc();
		j = i % 256;
		if (bcnt != 0) return 8'h00;
		if (st) return {wp_n, 1'b1, !ab, 5'h00};
		if (md == 8'h90 && adr == 8'h20) return i < 4 ? sig[i] : ~cur;
		if (md == 8'h90) return i < 5 ? t[i] : ~cur;
		if (md == 8'hEC && j >= 254) return j == 254 ? c[7:0] : c[15:8];
		if (md == 8'hEC) return j < 4 ? sig[j] : 8'h00;
		return ~cur;
	endfunction : byt
	always @(posedge pclk) begin
		we_q <= we_n;
		re_q <= re_n;
		if (bcnt != 0) bcnt <= bcnt - 1;
		if (we_n && !we_q && !ce_n && cle) begin
			st <= dq_i == 8'h70;
			pa <= dq_i == 8'hEC;
			// 70h and 00h leave the output mode and byte index alone
			if (dq_i != 8'h70 && dq_i != 8'h00) begin
				md  <= dq_i;
				idx <= 0;
			end
			if (dq_i == 8'h15 || dq_i == 8'h31) ab <= 1'b1;
			if (dq_i == 8'hFF) begin
				bcnt <= 20;
				ab   <= 1'b0;
			end
		end
		if (we_n && !we_q && !ce_n && ale) begin
			adr <= dq_i;
			pa  <= 1'b0;
			if (pa) bcnt <= 30;
		end
		if (!re_n && re_q && !ce_n) begin
			cur <= byt(idx);
			if (!st) idx <= idx + 1;
		end
	end
	assign rb_n = bcnt == 0;
	// released bus shows the inverse, never a stale byte
	assign dq_o = (!re_n || !re_q) ? cur : ~cur;
endmodule : nric_tgt
`default_nettype wire

// ### nric_host_tb.sv
// self-checking bench for the nand command host with a target model
`timescale 1ns/1ps
`default_nettype none
module nric_host_tb;
	import nric_pkg::*;
	localparam logic [7:0] MFR = 8'h5A; // arbitrary
	localparam logic [7:0] DEV = 8'hA5; // arbitrary
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00, dq_o, dq_t, dq;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, ce_n, cle, ale, we_n, re_n, wp_n, oe_n, rb_n;
	logic [7:0]  sg [4] = '{8'h4F, 8'h4E, 8'h46, 8'h49};
	logic [7:0]  ids [5] = '{MFR, DEV, 8'h80, 8'h26, 8'h62};
	int          n_fail = 0, check_count = 0;
	always #5 pclk = ~pclk;
	assign dq = oe_n ? dq_t : dq_o;
	nric_host #(.BUSY_MAX_CYC(200), .OTP_FEAT(8'h90)) u_dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .nand_ce_n(ce_n), .nand_cle(cle),
		.nand_ale(ale), .nand_we_n(we_n), .nand_re_n(re_n), .nand_wp_n(wp_n),
		.nand_dq_o(dq_o), .nand_dq_oe_n(oe_n), .nand_dq_i(dq), .nand_rb_n(rb_n));
	nric_tgt #(.MFR(MFR), .DEV(DEV)) u_tgt (.pclk(pclk), .ce_n(ce_n), .cle(cle), .ale(ale),
		.we_n(we_n), .re_n(re_n), .wp_n(wp_n), .dq_i(dq), .dq_o(dq_t), .rb_n(rb_n));
	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : end_sim
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic chk(input string nm, input logic [31:0] m, input logic [31:0] e);
		check_count++;
		if ((rd & m) !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, rd & m);
		end
	endtask : chk
	// polls busy so the next cycle is never refused for overlap
	task automatic cyc(input logic [7:0] b, input logic [1:0] k);
		apb(1'b1, A_CYCLE, {22'h0, k, b});
		do apb(1'b0, A_STATUS, 32'h0); while (rd[0] !== 1'b0);
	endtask : cyc
	task automatic rbyte(input logic [7:0] e);
		cyc(8'h00, K_DOUT);
		chk("read byte", 32'h00FF0000, {8'h00, e, 16'h0000});
	endtask : rbyte
	task automatic seq(input logic [7:0] f, input int n, input logic dn, input logic [7:0] c,
		input logic r);
		apb(1'b1, A_ERRCLR, 32'h7);
		cyc(f, K_CMD);
		repeat (n) cyc(8'h00, K_ADDR);
		if (dn) cyc(8'hA5, K_DIN);
		cyc(c, K_CMD);
		chk("otp refused", 32'h100, {23'h0, r, 8'h00});
	endtask : seq
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		cyc(C_READ_ID, K_CMD);
		chk("refused", 32'h100, 32'h100);
		apb(1'b1, A_CTRL, 32'h1);
		apb(1'b1, A_ERRCLR, 32'h7);
		cyc(C_RESET, K_CMD);
		chk("init", 32'h305, 32'h004);
		cyc(C_STATUS, K_CMD);
		rbyte(8'hE0);
		chk("mismatch", 32'h400, 32'h0);
		apb(1'b1, A_CTRL, 32'h0);
		cyc(C_RESET, K_CMD);
		cyc(C_STATUS, K_CMD);
		rbyte(8'h60);
		$display("test reset done");
		cyc(C_READ_ID, K_CMD);
		cyc(8'h20, K_ADDR);
		for (int i = 0; i < 4; i++) rbyte(sg[i]);
		chk("id mode", 32'h18, 32'h08);
		cyc(C_READ_ID, K_CMD);
		cyc(8'h00, K_ADDR);
		for (int i = 0; i < 5; i++) rbyte(ids[i]);
		$display("test read id done");
		cyc(C_PARAM, K_CMD);
		cyc(8'h00, K_ADDR);
		chk("param mode", 32'h19, 32'h10);
		cyc(C_STATUS, K_CMD);
		rbyte(8'h60);
		cyc(C_READ, K_CMD);
		apb(1'b1, A_ERRCLR, 32'h7);
		cyc(C_STATUS_ENH, K_CMD);
		chk("enhanced status refused", 32'h100, 32'h100);
		for (int i = 0; i < 4; i++) rbyte(sg[i]);
		for (int i = 4; i < 256; i++) cyc(8'h00, K_DOUT);
		chk("crc", 32'hC0, 32'hC0);
		$display("test parameter page done");
		apb(1'b1, A_CTRL, 32'h3);
		seq(C_PROG, 5, 1'b0, C_CONF_PROG, 1'b1);
		cyc(C_SET_FEAT, K_CMD);
		cyc(8'h90, K_ADDR);
		chk("otp enabled", 32'h20, 32'h20);
		seq(C_PROG, 5, 1'b0, C_CONF_PROG, 1'b0);
		seq(C_PROG, 4, 1'b0, C_CONF_PROG, 1'b1);
		seq(C_PROG, 5, 1'b1, C_CONF_PROG, 1'b0);
		seq(C_READ, 5, 1'b0, C_CONF_READ, 1'b0);
		seq(C_READ, 5, 1'b1, C_CONF_READ, 1'b1);
		$display("test otp done");
		apb(1'b1, A_CTRL, 32'h1);
		seq(C_PROG, 5, 1'b1, C_CONF_CACHEP, 1'b0);
		cyc(C_STATUS, K_CMD);
		rbyte(8'hC0);
		seq(C_PROG, 5, 1'b1, C_CONF_CACHEP, 1'b0);
		seq(C_READ, 5, 1'b0, C_CONF_READ, 1'b0);
		seq(C_PROG, 5, 1'b1, C_CONF_CACHEP, 1'b1);
		seq(C_CACHE_SEQ, 0, 1'b0, C_CACHE_LAST, 1'b0);
		seq(C_SET_FEAT, 1, 1'b0, C_CACHE_SEQ, 1'b1);
		$display("test cache done");
		apb(1'b0, 8'h14, 32'h0);
		chk("unmapped", 32'hFFFFFFFF, 32'h0);
		$display("test unmapped done");
		end_sim();
	end
	initial begin
		#900000;
		n_fail++;
		end_sim();
	end
endmodule : nric_host_tb
`default_nettype wire
